// ---- hw/hsb_config.sv ----
// slot B channel configuration, system configuration and interrupt latch
`default_nettype none
`include "hsb_regs.svh"

module hsb_config
	import hsb_pkg::*;
#(
	parameter int TICK_CYCLES = `HSB_TICK_NS / `HSB_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic nrst_in,
	// register port from the serial management front end
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// analog comparators and pins, asynchronous
	input wire logic b_high_rail_output_low_in,
	input wire logic b_low_rail_output_low_in,
	input wire logic b_high_rail_overcurrent_in,
	input wire logic b_low_rail_overcurrent_in,
	input wire logic b_high_rail_pg_in,
	input wire logic b_low_rail_pg_in,
	input wire logic b_high_rail_below_limit_in,
	input wire logic b_low_rail_reverse_in,
	input wire logic b_low_rail_enable_pin_in,
	// slot A and shared logic, same clock
	input wire logic [3:0] slot_a_status_set_in,
	input wire logic [3:0] high_rail_current_limit_code_in,
	// slot B drives
	output logic b_pass_gate_out,
	output logic b_block_gate_out,
	output logic b_fast_pulldown_out,
	output logic b_low_rail_gate_out,
	output logic b_high_rail_bleed_connect_out,
	output logic b_low_rail_bleed_connect_out,
	output logic [3:0] b_high_rail_current_limit_code_out,
	// system settings for slot A and interrupt pin
	output hsb_sys_cfg_s sys_config_out,
	output logic irq_out_n
);

	localparam logic [10:0] FAST_CYCLES = 11'(`HSB_FAST_OFF_NS / `HSB_CLK_PERIOD_NS);

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	// every comparator is treated as asynchronous to mclk_in
	hsb_sense_s raw, sync1, sense;

	assign raw = '{b_high_rail_output_low_in, b_low_rail_output_low_in,
		b_high_rail_overcurrent_in, b_low_rail_overcurrent_in, b_high_rail_pg_in,
		b_low_rail_pg_in, b_high_rail_below_limit_in, b_low_rail_reverse_in,
		b_low_rail_enable_pin_in};

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1 <= '0;
			sense <= '0;
		end else begin
			sync1 <= raw;
			sense <= sync1;
		end
	end

	// ****************************************************************
	// 0.5 ms timebase
	// ****************************************************************
	logic [15:0] tick_cnt, next_tick_cnt;
	logic tick, next_tick;
	// one registered pulse feeds both timers so they step together

	always_comb begin
		next_tick = 1'b0;
		next_tick_cnt = tick_cnt + 16'h0001;
		if (tick_cnt >= 16'(TICK_CYCLES - 1)) begin
			next_tick_cnt = 16'h0000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tick_cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	// ****************************************************************
	// register bank
	// ****************************************************************
	hsb_chan_cfg_s cfg_high, next_cfg_high;
	hsb_chan_cfg_s cfg_low, next_cfg_low;
	hsb_sys_cfg_s sys, next_sys;
	logic [7:0] status, next_status, status_set;
	logic [7:0] next_rdata;
	logic next_irq_n;
	logic high_fault, low_fault;
	logic [1:0] pg_prev, next_pg_prev;

	assign next_pg_prev = {sense.high_pg, sense.low_pg};
	// power-good loss is a falling edge of the comparator level
	assign status_set = {low_fault, pg_prev[0] & ~sense.low_pg,
		high_fault, pg_prev[1] & ~sense.high_pg, slot_a_status_set_in};

	// ****************************************************************
	// interrupt pin
	// ****************************************************************
	logic slot_a_pending, slot_b_pending;

	// the pin follows the latch, so unmasking asserts any bit still pending
	assign slot_a_pending = (|status[3:0]) & ~sys.slot_a_irq_mask;
	assign slot_b_pending = (|status[7:4]) & ~sys.slot_b_irq_mask;

	always_comb begin
		next_cfg_high = cfg_high;
		next_cfg_low = cfg_low;
		next_sys = sys;
		next_status = status;
		next_rdata = reg_rdata_out;
		if (reg_wr_in) begin
			case (reg_addr_in)
				`HSB_ADDR_HIGH_CFG: next_cfg_high = hsb_chan_cfg_s'(reg_wdata_in);
				`HSB_ADDR_LOW_CFG: next_cfg_low = hsb_chan_cfg_s'(reg_wdata_in);
				// spare bit is stored as written; software keeps it zero
				`HSB_ADDR_SYS_CFG: next_sys = hsb_sys_cfg_s'(reg_wdata_in);
				// status is read-only; writes to it are dropped
				default: ;
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				`HSB_ADDR_HIGH_CFG: next_rdata = cfg_high;
				`HSB_ADDR_LOW_CFG: next_rdata = cfg_low;
				`HSB_ADDR_SYS_CFG: next_rdata = sys;
				`HSB_ADDR_IRQ_STATUS: begin
					next_rdata = status;
					next_status = `HSB_STATUS_RESET;
				end
				default: next_rdata = `HSB_READ_UNMAPPED;
			endcase
		end
		// an event in the read cycle survives the clear
		next_status = next_status | status_set;
		next_irq_n = ~(slot_a_pending | slot_b_pending);
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg_high <= `HSB_CHAN_CFG_RESET;
			cfg_low <= `HSB_CHAN_CFG_RESET;
			sys <= `HSB_SYS_CFG_RESET;
			status <= `HSB_STATUS_RESET;
			reg_rdata_out <= `HSB_READ_UNMAPPED;
			irq_out_n <= 1'b1;
			pg_prev <= 2'h0;
		end else begin
			cfg_high <= next_cfg_high;
			cfg_low <= next_cfg_low;
			sys <= next_sys;
			status <= next_status;
			reg_rdata_out <= next_rdata;
			irq_out_n <= next_irq_n;
			pg_prev <= next_pg_prev;
		end
	end

	assign sys_config_out = sys;
	// bleed switches follow the register bits with no extra delay
	assign b_high_rail_bleed_connect_out = cfg_high.bleed_connect;
	assign b_low_rail_bleed_connect_out = cfg_low.bleed_connect;

	// ****************************************************************
	// fault timers
	// ****************************************************************
	logic high_gate, next_high_gate;
	logic low_gate, next_low_gate;
	logic high_off, low_off, low_restart;
	logic low_chan_en;

	// only a low rail restart locks the high rail, so the high restart pulse is unused
	assign low_chan_en = cfg_low.enable & sense.low_enable_pin;

	hsb_fault_timer u_high_timer (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.tick_in(tick),
		.code_in(cfg_high.fault_time),
		.retry_mode_in(sys.fault_retry_mode),
		.chan_en_in(cfg_high.enable),
		.overcurrent_in(sense.high_overcurrent & high_gate),
		.off_out(high_off),
		.fault_out(high_fault),
		.restart_out()
	);

	hsb_fault_timer u_low_timer (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.tick_in(tick),
		.code_in(cfg_low.fault_time),
		.retry_mode_in(sys.fault_retry_mode),
		.chan_en_in(low_chan_en),
		.overcurrent_in(sense.low_overcurrent & low_gate),
		.off_out(low_off),
		.fault_out(low_fault),
		.restart_out(low_restart)
	);

	// ****************************************************************
	// gate control
	// ****************************************************************
	logic high_lock, next_high_lock;
	logic high_want, low_want;
	logic cross_off, high_blocked, reverse_off;
	logic [10:0] fast_cnt, next_fast_cnt;
	logic next_fast_out;
	logic boost, next_boost;
	logic [3:0] next_limit;

	always_comb begin
		// a low rail timeout also drops the high rail unless cross link is disabled
		cross_off = ~sys.cross_link_disable & low_off;
		// the restart pulse covers the cycle before the lock flip-flop is set
		high_blocked = high_lock | low_restart;
		high_want = cfg_high.enable & ~sys.pulldown_test & ~high_blocked & ~high_off
			& ~cross_off;
		reverse_off = sys.low_rail_oring_enable & sense.low_reverse;
		low_want = low_chan_en & ~low_off & ~reverse_off;
		// once on, the gate stays on while wanted; discharge check only gates turn-on
		next_high_gate = high_want
			& (high_gate | ~cfg_high.discharge_gate | sense.high_out_low);
		next_low_gate = low_want
			& (low_gate | ~cfg_low.discharge_gate | sense.low_out_low);
		// lock clears only while software holds the enable bit low
		next_high_lock = (high_lock & cfg_high.enable) | low_restart;
		// a new turn-off restarts the window; overlapping pulses do not add up
		next_fast_cnt = fast_cnt;
		if (high_gate && !next_high_gate) begin
			next_fast_cnt = FAST_CYCLES;
		end else if (fast_cnt != 11'h000) begin
			next_fast_cnt = fast_cnt - 11'h001;
		end
		next_fast_out = sys.pulldown_test | (next_fast_cnt != 11'h000);
		// boost covers each turn-on only; a later dip does not bring it back
		next_boost = sys.inrush_boost & next_high_gate
			& (~high_gate | (boost & ~sense.high_below_limit));
		next_limit = next_boost ? `HSB_CL_MAX : high_rail_current_limit_code_in;
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			high_gate <= 1'b0;
			low_gate <= 1'b0;
			high_lock <= 1'b0;
			fast_cnt <= 11'h000;
			b_fast_pulldown_out <= 1'b0;
			boost <= 1'b0;
			b_high_rail_current_limit_code_out <= 4'h0;
		end else begin
			high_gate <= next_high_gate;
			low_gate <= next_low_gate;
			high_lock <= next_high_lock;
			fast_cnt <= next_fast_cnt;
			b_fast_pulldown_out <= next_fast_out;
			boost <= next_boost;
			b_high_rail_current_limit_code_out <= next_limit;
		end
	end

	// both high rail gate pins share one drive; ORing control is handled elsewhere
	assign b_pass_gate_out = high_gate;
	assign b_block_gate_out = high_gate;
	assign b_low_rail_gate_out = low_gate;

endmodule : hsb_config

`default_nettype wire

// ---- hw/hsb_regs.svh ----
// register offsets, reset values and timing constants for the slot B configuration bank
`ifndef HSB_REGS_SVH
`define HSB_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define HSB_ADDR_HIGH_CFG 8'h04
`define HSB_ADDR_LOW_CFG 8'h05
`define HSB_ADDR_SYS_CFG 8'h06
`define HSB_ADDR_IRQ_STATUS 8'h07

// ****************************************************************
// reset values
// ****************************************************************
`define HSB_CHAN_CFG_RESET 8'h01
`define HSB_SYS_CFG_RESET 8'h00
`define HSB_STATUS_RESET 8'h00
`define HSB_READ_UNMAPPED 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define HSB_CLK_PERIOD_NS 10
`define HSB_TICK_NS 500000
`define HSB_FAST_OFF_NS 15000
`define HSB_RETRY_FACTOR 12'h064
`define HSB_CL_MAX 4'hF

`endif

// ---- hw/hsb_pkg.sv ----
// types shared by the slot B configuration bank and its fault timers
`default_nettype none

package hsb_pkg;

	// ****************************************************************
	// register layouts
	// ****************************************************************
	typedef struct packed {
		logic bleed_connect;
		logic discharge_gate;
		logic enable;
		logic [4:0] fault_time;
	} hsb_chan_cfg_s;

	typedef struct packed {
		logic cross_link_disable;
		logic slot_b_irq_mask;
		logic slot_a_irq_mask;
		logic inrush_boost;
		logic low_rail_oring_enable;
		logic spare;
		logic fault_retry_mode;
		logic pulldown_test;
	} hsb_sys_cfg_s;

	// ****************************************************************
	// synchronised comparator and pin levels
	// ****************************************************************
	typedef struct packed {
		logic high_out_low;
		logic low_out_low;
		logic high_overcurrent;
		logic low_overcurrent;
		logic high_pg;
		logic low_pg;
		logic high_below_limit;
		logic low_reverse;
		logic low_enable_pin;
	} hsb_sense_s;

	typedef enum logic {
		HSB_FT_RUN,
		HSB_FT_OFF
	} hsb_ft_state_e;

endpackage : hsb_pkg

`default_nettype wire

// ---- hw/hsb_fault_timer.sv ----
// per-channel fault timer with latch-off or timed retry
`default_nettype none
`include "hsb_regs.svh"

module hsb_fault_timer
	import hsb_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic nrst_in,
	// timebase and settings
	input wire logic tick_in,
	input wire logic [4:0] code_in,
	input wire logic retry_mode_in,
	// channel state
	input wire logic chan_en_in,
	input wire logic overcurrent_in,
	// results
	output logic off_out,
	output logic fault_out,
	output logic restart_out
);

	// ****************************************************************
	// state
	// ****************************************************************
	hsb_ft_state_e state, next_state;
	logic [11:0] cnt, next_cnt;
	logic [11:0] fault_target;
	logic [11:0] retry_target;
	logic next_fault, next_restart;

	assign fault_target = {7'h00, code_in};
	assign retry_target = 12'(`HSB_RETRY_FACTOR * {7'h00, code_in});
	assign off_out = (state == HSB_FT_OFF);

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_fault = 1'b0;
		next_restart = 1'b0;
		case (state)
			HSB_FT_RUN: begin
				// counting restarts whenever the overcurrent goes away
				if (!chan_en_in || !overcurrent_in) begin
					next_cnt = 12'h000;
				end else if (tick_in) begin
					if (cnt + 12'h001 >= fault_target) begin
						next_fault = 1'b1;
						next_state = HSB_FT_OFF;
						next_cnt = 12'h000;
					end else begin
						next_cnt = cnt + 12'h001;
					end
				end
			end
			HSB_FT_OFF: begin
				// cycling the enable clears a latched-off channel
				if (!chan_en_in) begin
					next_state = HSB_FT_RUN;
					next_cnt = 12'h000;
				end else if (retry_mode_in && tick_in) begin
					if (cnt + 12'h001 >= retry_target) begin
						next_restart = 1'b1;
						next_state = HSB_FT_RUN;
						next_cnt = 12'h000;
					end else begin
						next_cnt = cnt + 12'h001;
					end
				end
			end
			default: begin
				next_state = HSB_FT_RUN;
				next_cnt = 12'h000;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= HSB_FT_RUN;
			cnt <= 12'h000;
			fault_out <= 1'b0;
			restart_out <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			fault_out <= next_fault;
			restart_out <= next_restart;
		end
	end

endmodule : hsb_fault_timer

`default_nettype wire

// ---- verification/hsb_host.sv ----
// host model driving the pre-decoded register byte port
`default_nettype none
module hsb_host
	import hsb_pkg::*;
(
	// clock
	input wire logic mclk_in,
	// register port
	input wire logic [7:0] reg_rdata_in,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_addr_out <= a;
		reg_wdata_out <= (a == 8'h06) ? (d & 8'h7B) : d;
		reg_wr_out <= 1'b1;
		@(posedge mclk_in);
		reg_wr_out <= 1'b0;
		// stale data is not left on the port
		reg_wdata_out <= ~reg_wdata_out;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge mclk_in);
		reg_rd_out <= 1'b0;
		#1;
		d = reg_rdata_in;
	endtask : rd
endmodule : hsb_host
`default_nettype wire

// ---- verification/hsb_config_sva.sv ----
// assertions on the slot B configuration bank ports
`default_nettype none
module hsb_config_sva
	import hsb_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic nrst_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	// pins
	input wire logic b_low_rail_enable_pin_in,
	input wire logic [3:0] slot_a_status_set_in,
	input wire logic [3:0] high_rail_current_limit_code_in,
	// drives
	input wire logic b_pass_gate_out,
	input wire logic b_block_gate_out,
	input wire logic b_fast_pulldown_out,
	input wire logic b_low_rail_gate_out,
	input wire logic b_high_rail_bleed_connect_out,
	input wire logic b_low_rail_bleed_connect_out,
	input wire logic [3:0] b_high_rail_current_limit_code_out,
	input wire hsb_sys_cfg_s sys_config_out,
	input wire logic irq_out_n
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	// write strobe to one offset
	sequence s_wr(a);
		reg_wr_in && reg_addr_in == a;
	endsequence
	a_high_en_off: assert property (s_wr(8'h04) ##0 !reg_wdata_in[5] |-> ##3 !b_pass_gate_out)
		else $error("pass gate on after enable cleared");
	a_block_follows: assert property (s_wr(8'h04) ##0 !reg_wdata_in[5] |-> ##3 !b_block_gate_out)
		else $error("block gate on after enable cleared");
	a_high_bleed: assert property (s_wr(8'h04) |-> ##2
		b_high_rail_bleed_connect_out == $past(reg_wdata_in[7], 2))
		else $error("high bleed output wrong");
	a_low_bleed: assert property (s_wr(8'h05) |-> ##2
		b_low_rail_bleed_connect_out == $past(reg_wdata_in[7], 2))
		else $error("low bleed output wrong");
	a_sys_cfg_out: assert property (s_wr(8'h06) |-> ##2 sys_config_out == $past(reg_wdata_in, 2))
		else $error("system settings output wrong");
	a_low_pin_off: assert property (!b_low_rail_enable_pin_in [*4] |-> !b_low_rail_gate_out)
		else $error("low gate on with pin low");
	a_slot_a_irq: assert property (slot_a_status_set_in != 4'h0 && !sys_config_out.slot_a_irq_mask
		|-> ##2 !irq_out_n)
		else $error("unmasked slot A event without interrupt");
	a_pulldown_hold: assert property (sys_config_out.pulldown_test [*3]
		|-> b_fast_pulldown_out && !b_pass_gate_out)
		else $error("pulldown test not holding drivers");
	a_limit_normal: assert property (!sys_config_out.inrush_boost [*3]
		|-> b_high_rail_current_limit_code_out == $past(high_rail_current_limit_code_in))
		else $error("limit code not programmed value");
endmodule : hsb_config_sva
`default_nettype wire

// ---- verification/hsb_config_tb.sv ----
// self-checking bench for the slot B configuration bank
`default_nettype none
module hsb_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// short tick keeps fault and retry times small
	localparam int T = 10;
	logic mclk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic hol = 1'b1, lol = 1'b1, hoc = 1'b0, loc = 1'b0, hpg = 1'b1, lpg = 1'b1;
	logic hbl = 1'b0, lrev = 1'b0, lpin = 1'b0;
	logic [3:0] sta = 4'h0, clc = 4'h5, clo;
	logic [7:0] addr, wdata, rdata;
	logic wr, rd, pass, blk, fpd, lgate, hbc, lbc, irq_n;
	hsb_pkg::hsb_sys_cfg_s sys;
	int n_mismatch = 0;
	int checked = 0;
	int c;
	always #5 mclk_in = ~mclk_in;
	hsb_host hsb_host_inst (.mclk_in(mclk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
		.reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));
	hsb_config #(.TICK_CYCLES(T)) hsb_config_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .b_high_rail_output_low_in(hol), .b_low_rail_output_low_in(lol),
		.b_high_rail_overcurrent_in(hoc), .b_low_rail_overcurrent_in(loc),
		.b_high_rail_pg_in(hpg), .b_low_rail_pg_in(lpg), .b_high_rail_below_limit_in(hbl),
		.b_low_rail_reverse_in(lrev), .b_low_rail_enable_pin_in(lpin),
		.slot_a_status_set_in(sta), .high_rail_current_limit_code_in(clc),
		.b_pass_gate_out(pass), .b_block_gate_out(blk), .b_fast_pulldown_out(fpd),
		.b_low_rail_gate_out(lgate), .b_high_rail_bleed_connect_out(hbc),
		.b_low_rail_bleed_connect_out(lbc), .b_high_rail_current_limit_code_out(clo),
		.sys_config_out(sys), .irq_out_n(irq_n));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chk_cnt(input string n, input int lo, input int hi);
		checked++;
		if (c < lo || c > hi) begin
			n_mismatch++;
			$display("unexpected %s: expected %0d to %0d seen %0d", n, lo, hi, c);
		end
	endtask : chk_cnt
	task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		hsb_host_inst.rd(a, d);
		chk(n, e, d);
	endtask : rdc
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : cyc
	// bounded wait for the pass gate, cycles left in c
	task automatic wait_pass(input logic e, input int lim);
		c = 0;
		while (pass !== e) begin
			cyc(1);
			c++;
			if (c > lim) begin
				n_mismatch++;
				$display("unexpected pass gate wait: expected %b seen %b", e, pass);
				end_of_test();
			end
		end
	endtask : wait_pass
	initial begin
		#200000;
		n_mismatch++;
		$display("unexpected run length: expected end seen timeout");
		end_of_test();
	end
	initial begin
		repeat (20) @(posedge mclk_in);
		nrst_in <= 1'b1;
		rdc("high cfg", 8'h04, 8'h01);
		rdc("low cfg", 8'h05, 8'h01);
		rdc("sys cfg", 8'h06, 8'h00);
		rdc("status", 8'h07, 8'h00);
		rdc("unmapped", 8'h08, 8'h00);
		$display("reset test done");
		hsb_host_inst.wr(8'h04, 8'h85);
		rdc("high cfg", 8'h04, 8'h85);
		hsb_host_inst.wr(8'h05, 8'h1F);
		rdc("low cfg", 8'h05, 8'h1F);
		cyc(3);
		chk("high bleed", 1, hbc);
		chk("low bleed", 0, lbc);
		hol <= 1'b0;
		hsb_host_inst.wr(8'h04, 8'h61);
		cyc(8);
		chk("pass gate", 0, pass);
		hol <= 1'b1;
		cyc(6);
		chk("pass gate", 1, pass);
		chk("block gate", 1, blk);
		hsb_host_inst.wr(8'h04, 8'h01);
		cyc(4);
		chk("block gate", 0, blk);
		hsb_host_inst.wr(8'h05, 8'h21);
		cyc(8);
		chk("low gate", 0, lgate);
		lpin <= 1'b1;
		cyc(6);
		chk("low gate", 1, lgate);
		hsb_host_inst.wr(8'h06, 8'h08);
		lrev <= 1'b1;
		cyc(6);
		chk("low gate", 0, lgate);
		hsb_host_inst.wr(8'h06, 8'h00);
		cyc(6);
		chk("low gate", 1, lgate);
		lrev <= 1'b0;
		hsb_host_inst.wr(8'h05, 8'h01);
		$display("gate test done");
		hsb_host_inst.wr(8'h04, 8'h22);
		wait_pass(1, 20);
		hoc <= 1'b1;
		wait_pass(0, 5 * T);
		chk_cnt("fault time", T, 2 * T + 6);
		cyc(40);
		chk("pass gate", 0, pass);
		chk("irq", 0, irq_n);
		rdc("status", 8'h07, 8'h20);
		cyc(2);
		chk("irq", 1, irq_n);
		hsb_host_inst.wr(8'h06, 8'h02);
		hsb_host_inst.wr(8'h04, 8'h02);
		hsb_host_inst.wr(8'h04, 8'h22);
		wait_pass(1, 20);
		wait_pass(0, 5 * T);
		wait_pass(1, 210 * T);
		chk_cnt("retry time", 195 * T, 205 * T);
		hoc <= 1'b0;
		hsb_host_inst.wr(8'h04, 8'h02);
		rdc("status", 8'h07, 8'h20);
		$display("fault test done");
		hsb_host_inst.wr(8'h04, 8'h21);
		hsb_host_inst.wr(8'h06, 8'h01);
		cyc(2000);
		chk("fast pulldown", 1, fpd);
		chk("pass gate", 0, pass);
		hsb_host_inst.wr(8'h06, 8'h00);
		cyc(6);
		chk("pass gate", 1, pass);
		hsb_host_inst.wr(8'h04, 8'h01);
		$display("pulldown test done");
		hsb_host_inst.wr(8'h06, 8'h20);
		cyc(2);
		@(posedge mclk_in) sta <= 4'h1;
		@(posedge mclk_in) sta <= 4'h0;
		cyc(4);
		chk("irq", 1, irq_n);
		rdc("status", 8'h07, 8'h01);
		hsb_host_inst.wr(8'h06, 8'h00);
		cyc(2);
		@(posedge mclk_in) sta <= 4'h8;
		@(posedge mclk_in) sta <= 4'h0;
		cyc(3);
		chk("irq", 0, irq_n);
		rdc("status", 8'h07, 8'h08);
		$display("mask test done");
		hsb_host_inst.wr(8'h06, 8'h10);
		hsb_host_inst.wr(8'h04, 8'h21);
		cyc(6);
		chk("limit code", 8'h0F, clo);
		hbl <= 1'b1;
		cyc(6);
		chk("limit code", 8'h05, clo);
		hsb_host_inst.wr(8'h04, 8'h01);
		$display("inrush test done");
		lol <= 1'b0;
		hsb_host_inst.wr(8'h06, 8'h42);
		hsb_host_inst.wr(8'h04, 8'h21);
		hsb_host_inst.wr(8'h05, 8'h61);
		cyc(8);
		chk("low gate", 0, lgate);
		lol <= 1'b1;
		cyc(6);
		chk("low gate", 1, lgate);
		chk("pass gate", 1, pass);
		loc <= 1'b1;
		lpg <= 1'b0;
		cyc(20);
		chk("pass gate", 0, pass);
		chk("irq", 1, irq_n);
		loc <= 1'b0;
		lpg <= 1'b1;
		cyc(1100);
		chk("low gate", 1, lgate);
		chk("pass gate", 0, pass);
		hsb_host_inst.wr(8'h04, 8'h01);
		hsb_host_inst.wr(8'h04, 8'h21);
		cyc(6);
		chk("pass gate", 1, pass);
		hsb_host_inst.wr(8'h06, 8'h00);
		cyc(3);
		chk("irq", 0, irq_n);
		rdc("status", 8'h07, 8'hC0);
		hsb_host_inst.wr(8'h04, 8'h01);
		hsb_host_inst.wr(8'h05, 8'h01);
		$display("cross link test done");
		end_of_test();
	end
endmodule : hsb_config_tb
bind hsb_config hsb_config_sva hsb_config_sva_inst (.mclk_in, .nrst_in, .reg_addr_in,
	.reg_wr_in, .reg_wdata_in, .b_low_rail_enable_pin_in, .slot_a_status_set_in,
	.high_rail_current_limit_code_in, .b_pass_gate_out, .b_block_gate_out,
	.b_fast_pulldown_out, .b_low_rail_gate_out, .b_high_rail_bleed_connect_out,
	.b_low_rail_bleed_connect_out, .b_high_rail_current_limit_code_out, .sys_config_out,
	.irq_out_n);
`default_nettype wire
